// *** rtl/lbe_consts.vh ***
// Opcode encodings, widths, depths and step counts of the boolean engine.
`ifndef LBE_CONSTS_VH
`define LBE_CONSTS_VH
`define LBE_OP_W         5
`define LBE_OP_NOP       5'h00
`define LBE_OP_LOAD      5'h01
`define LBE_OP_LOAD_INV  5'h02
`define LBE_OP_COIL      5'h03
`define LBE_OP_INVERT    5'h04
`define LBE_OP_SER       5'h05
`define LBE_OP_SER_INV   5'h06
`define LBE_OP_PAR       5'h07
`define LBE_OP_PAR_INV   5'h08
`define LBE_OP_LOAD_RISE 5'h09
`define LBE_OP_LOAD_FALL 5'h0A
`define LBE_OP_SER_RISE  5'h0B
`define LBE_OP_SER_FALL  5'h0C
`define LBE_OP_PAR_RISE  5'h0D
`define LBE_OP_PAR_FALL  5'h0E
`define LBE_OP_PULS_RISE 5'h0F
`define LBE_OP_PULS_FALL 5'h10
`define LBE_OP_TOGGLE    5'h11
`define LBE_OP_BLK_SER   5'h12
`define LBE_OP_BLK_PAR   5'h13
`define LBE_OP_PUSH      5'h14
`define LBE_OP_PEEK      5'h15
`define LBE_OP_POP       5'h16
`define LBE_OP_RISE_PLS  5'h17
`define LBE_OP_FALL_PLS  5'h18
`define LBE_ADDR_W       16
`define LBE_EDGE_ID_W    8
`define LBE_EDGE_DEPTH   256
`define LBE_STACK_DEPTH  8
`define LBE_SP_W         4
`define LBE_STEP_W       2
`define LBE_STEPS_ONE    2'h1
`define LBE_STEPS_TWO    2'h2
`define LBE_STEPS_THREE  2'h3
`define LBE_ERR_OVER     2'h1
`define LBE_ERR_UNDER    2'h2
`endif

// *** rtl/lbe_edge_mem.v ***
// Per-instance previous-scan sample memory with registered read data.
`timescale 1ns/10ps
`include "lbe_consts.vh"
module lbe_edge_mem (
   // Clock and reset
   input  wire                       clock,
   input  wire                       reset_n,
   // Read port
   input  wire [`LBE_EDGE_ID_W-1:0]  rd_addr,
   output reg                        rd_data_r,
   // Write port
   input  wire                       wr_en,
   input  wire [`LBE_EDGE_ID_W-1:0]  wr_addr,
   input  wire                       wr_data
);
   reg [`LBE_EDGE_DEPTH-1:0] mem_r;

   // Samples start low so a level already high at reset counts as a rise.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_r     <= {`LBE_EDGE_DEPTH{1'b0}};
         rd_data_r <= 1'b0;
      end else begin
         if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
         end
         rd_data_r <= mem_r[rd_addr];
      end
   end
endmodule

// *** rtl/lbe_engine.v ***
// Single-bit relay-ladder boolean execution unit.
// Functional notes
// - Load starts result from operand bit; one step, two if extended.
// - Inverted load starts result from complemented operand; one or two.
// - Coil write copies result to addressed bit; one or two steps.
// - Invert complements the result; exactly one step.
// - Series contact ANDs result with operand; one or two steps.
// - Series inverted ANDs result with complemented operand; one/two.
// - Parallel contact ORs result with operand; one or two steps.
// - Parallel inverted ORs result with complemented operand; one/two.
// - Edge load gives true one scan after operand edge; two steps.
// - Edge series ANDs result with one-scan edge term; two steps.
// - Edge parallel ORs result with one-scan edge term; two steps.
// - Pulse write drives relay one scan after result edge; two steps.
// - Toggle coil inverts stored bit on result rise; three steps.
// - Block series join ANDs stacked block with current; one step.
// - Block parallel join ORs stacked block with current; one step.
// - Push saves result on stack unchanged; one step.
// - Peek loads result from stack top, keeping it; one step.
// - Pop loads result from stack top and removes it; one step.
// - Rise or fall pulse makes result true one scan on edge; one step.
`timescale 1ns/10ps
`include "lbe_consts.vh"
module lbe_engine (
   // Clock and reset
   input  wire                       clock,
   input  wire                       reset_n,
   // Instruction from the sequencer
   input  wire                       instr_valid,
   input  wire [`LBE_OP_W-1:0]       instr_op,
   input  wire [`LBE_ADDR_W-1:0]     instr_addr,
   input  wire                       instr_ext,
   input  wire [`LBE_EDGE_ID_W-1:0]  instr_edge_id,
   input  wire                       scan_start,
   output wire                       instr_ready,
   // Operand bit memory
   input  wire                       operand_bit,
   output reg                        bit_wr_en_r,
   output reg  [`LBE_ADDR_W-1:0]     bit_wr_addr_r,
   output reg                        bit_wr_data_r,
   // Status
   output reg                        result_r,
   output reg  [`LBE_STEP_W-1:0]     instr_steps_r,
   output reg                        done_r,
   output reg                        prog_error_r,
   output reg  [1:0]                 error_code_r,
   output reg  [`LBE_SP_W-1:0]       stack_level_r
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_EXEC = 2'b10;

   reg  [1:0]                     state_r;
   reg  [1:0]                     state_nxt;
   reg  [`LBE_OP_W-1:0]           op_r;
   reg  [`LBE_ADDR_W-1:0]         addr_r;
   reg  [`LBE_EDGE_ID_W-1:0]      edge_id_r;
   reg                            ext_r;
   reg                            opnd_r;
   reg  [`LBE_STACK_DEPTH-1:0]    stack_r;
   reg                            result_nxt;
   reg                            push_en;
   reg                            pop_en;
   reg                            need_top;
   reg                            wr_en_nxt;
   reg                            wr_data_nxt;
   reg                            edge_in;
   reg                            edge_wr;
   wire                           prev_sample;
   wire                           top_bit;
   wire                           stack_empty;
   wire                           stack_full;
   wire                           rise;
   wire                           fall;

   // The sample memory is read while the operand is captured, so each
   // instruction costs two clocks and the previous-scan value is ready.
   lbe_edge_mem u_edge (
      .clock     (clock),
      .reset_n   (reset_n),
      .rd_addr   (instr_edge_id),
      .rd_data_r (prev_sample),
      .wr_en     (edge_wr),
      .wr_addr   (edge_id_r),
      .wr_data   (edge_in)
   );

   // Step count of an opcode as laid out in program memory.
   function [`LBE_STEP_W-1:0] lbe_steps;
      input [`LBE_OP_W-1:0] op;
      input                 ext;
      begin
         if (op == `LBE_OP_LOAD || op == `LBE_OP_LOAD_INV ||
             op == `LBE_OP_COIL || op == `LBE_OP_SER ||
             op == `LBE_OP_SER_INV || op == `LBE_OP_PAR ||
             op == `LBE_OP_PAR_INV) begin
            lbe_steps = ext ? `LBE_STEPS_TWO : `LBE_STEPS_ONE;
         end else if (op == `LBE_OP_TOGGLE) begin
            lbe_steps = `LBE_STEPS_THREE;
         end else if (op >= `LBE_OP_LOAD_RISE && op <= `LBE_OP_PULS_FALL) begin
            lbe_steps = `LBE_STEPS_TWO;
         end else begin
            lbe_steps = `LBE_STEPS_ONE;
         end
      end
   endfunction

   assign instr_ready = state_r[0];
   assign top_bit     = (stack_level_r == {`LBE_SP_W{1'b0}}) ? 1'b0 :
                        stack_r[stack_level_r[`LBE_SP_W-2:0] - 3'h1];
   assign stack_empty = (stack_level_r == {`LBE_SP_W{1'b0}});
   assign stack_full  = (stack_level_r == `LBE_STACK_DEPTH);
   assign rise        = edge_in & ~prev_sample;
   assign fall        = ~edge_in & prev_sample;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (instr_valid) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Datapath of one instruction, evaluated in the execute cycle.
   always @* begin
      result_nxt  = result_r;
      push_en     = 1'b0;
      pop_en      = 1'b0;
      need_top    = 1'b0;
      wr_en_nxt   = 1'b0;
      wr_data_nxt = 1'b0;
      edge_wr     = 1'b0;
      edge_in     = opnd_r;
      if (op_r == `LBE_OP_PULS_RISE || op_r == `LBE_OP_PULS_FALL ||
          op_r == `LBE_OP_TOGGLE || op_r == `LBE_OP_RISE_PLS ||
          op_r == `LBE_OP_FALL_PLS) begin
         edge_in = result_r;
      end
      if (state_r == ST_EXEC) begin
         case (op_r)
            `LBE_OP_LOAD:      result_nxt = opnd_r;
            `LBE_OP_LOAD_INV:  result_nxt = ~opnd_r;
            `LBE_OP_COIL: begin
               wr_en_nxt   = 1'b1;
               wr_data_nxt = result_r;
            end
            `LBE_OP_INVERT:    result_nxt = ~result_r;
            `LBE_OP_SER:       result_nxt = result_r & opnd_r;
            `LBE_OP_SER_INV:   result_nxt = result_r & ~opnd_r;
            `LBE_OP_PAR:       result_nxt = result_r | opnd_r;
            `LBE_OP_PAR_INV:   result_nxt = result_r | ~opnd_r;
            `LBE_OP_LOAD_RISE: result_nxt = rise;
            `LBE_OP_LOAD_FALL: result_nxt = fall;
            `LBE_OP_SER_RISE:  result_nxt = result_r & rise;
            `LBE_OP_SER_FALL:  result_nxt = result_r & fall;
            `LBE_OP_PAR_RISE:  result_nxt = result_r | rise;
            `LBE_OP_PAR_FALL:  result_nxt = result_r | fall;
            `LBE_OP_PULS_RISE: begin
               wr_en_nxt   = 1'b1;
               wr_data_nxt = rise;
            end
            `LBE_OP_PULS_FALL: begin
               wr_en_nxt   = 1'b1;
               wr_data_nxt = fall;
            end
            `LBE_OP_TOGGLE: begin
               wr_en_nxt   = rise;
               wr_data_nxt = ~opnd_r;
            end
            `LBE_OP_BLK_SER: begin
               need_top   = 1'b1;
               pop_en     = 1'b1;
               result_nxt = top_bit & result_r;
            end
            `LBE_OP_BLK_PAR: begin
               need_top   = 1'b1;
               pop_en     = 1'b1;
               result_nxt = top_bit | result_r;
            end
            `LBE_OP_PUSH:      push_en = 1'b1;
            `LBE_OP_PEEK: begin
               need_top   = 1'b1;
               result_nxt = top_bit;
            end
            `LBE_OP_POP: begin
               need_top   = 1'b1;
               pop_en     = 1'b1;
               result_nxt = top_bit;
            end
            `LBE_OP_RISE_PLS:  result_nxt = rise;
            `LBE_OP_FALL_PLS:  result_nxt = fall;
            default:           result_nxt = result_r;
         endcase
         if (op_r >= `LBE_OP_LOAD_RISE && op_r <= `LBE_OP_TOGGLE) begin
            edge_wr = 1'b1;
         end
         if (op_r == `LBE_OP_RISE_PLS || op_r == `LBE_OP_FALL_PLS) begin
            edge_wr = 1'b1;
         end
         // An empty stack leaves the result untouched rather than corrupt.
         if (need_top && stack_empty) begin
            result_nxt = result_r;
            pop_en     = 1'b0;
         end
         if (push_en && stack_full) begin
            push_en = 1'b0;
         end
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r       <= ST_IDLE;
         op_r          <= `LBE_OP_NOP;
         addr_r        <= {`LBE_ADDR_W{1'b0}};
         ext_r         <= 1'b0;
         opnd_r        <= 1'b0;
         edge_id_r     <= {`LBE_EDGE_ID_W{1'b0}};
         stack_r       <= {`LBE_STACK_DEPTH{1'b0}};
         stack_level_r <= {`LBE_SP_W{1'b0}};
         result_r      <= 1'b0;
         instr_steps_r <= `LBE_STEPS_ONE;
         done_r        <= 1'b0;
         bit_wr_en_r   <= 1'b0;
         bit_wr_addr_r <= {`LBE_ADDR_W{1'b0}};
         bit_wr_data_r <= 1'b0;
         prog_error_r  <= 1'b0;
         error_code_r  <= 2'h0;
      end else begin
         state_r     <= state_nxt;
         done_r      <= (state_r == ST_EXEC);
         bit_wr_en_r <= wr_en_nxt;
         if (state_r == ST_IDLE && instr_valid) begin
            op_r      <= instr_op;
            addr_r    <= instr_addr;
            ext_r     <= instr_ext;
            opnd_r    <= operand_bit;
            edge_id_r <= instr_edge_id;
         end
         if (state_r == ST_EXEC) begin
            result_r      <= result_nxt;
            instr_steps_r <= lbe_steps(op_r, ext_r);
            bit_wr_addr_r <= addr_r;
            bit_wr_data_r <= wr_data_nxt;
            if (push_en) begin
               stack_r[stack_level_r[`LBE_SP_W-2:0]] <= result_r;
               stack_level_r <= stack_level_r + 4'h1;
            end else if (pop_en) begin
               stack_level_r <= stack_level_r - 4'h1;
            end
         end
         // Errors are sticky within a scan; a new scan clears them.
         if (state_r == ST_EXEC && need_top && stack_empty) begin
            prog_error_r <= 1'b1;
            error_code_r <= `LBE_ERR_UNDER;
         end else if (state_r == ST_EXEC && op_r == `LBE_OP_PUSH &&
                      stack_full) begin
            prog_error_r <= 1'b1;
            error_code_r <= `LBE_ERR_OVER;
         end else if (scan_start) begin
            prog_error_r  <= 1'b0;
            error_code_r  <= 2'h0;
         end
      end
   end
endmodule

// *** verification/lbe_bit_mem.sv ***
// Operand bit memory model on the far side of the boolean engine.
`timescale 1ns/10ps
`include "lbe_consts.vh"
module lbe_bit_mem (
   // Clock
   input wire                   clock,
   // Read side
   input wire [`LBE_ADDR_W-1:0] rd_addr,
   output wire                  rd_bit,
   // Write side
   input wire                   wr_en,
   input wire [`LBE_ADDR_W-1:0] wr_addr,
   input wire                   wr_data
);
   // Odd addresses power up set, so the bench needs no preload path.
   reg     mem_r [0:255];
   integer i;
   initial begin
      for (i = 0; i < 256; i = i + 1) begin
         mem_r[i] = i[0];
      end
   end
   // A write lands one edge late; reads see the old bit until then.
   assign rd_bit = mem_r[rd_addr[7:0]];
   always @(posedge clock) begin
      if (wr_en) begin
         mem_r[wr_addr[7:0]] <= wr_data;
      end
   end
endmodule

// *** verification/lbe_engine_chk.sv ***
// Concurrent checks on the boolean engine ports.
`timescale 1ns/10ps
`include "lbe_consts.vh"
module lbe_engine_chk (
   // Clock and reset
   input wire                   clock,
   input wire                   reset_n,
   // Instruction and operand
   input wire                   instr_valid,
   input wire [`LBE_OP_W-1:0]   instr_op,
   input wire [`LBE_ADDR_W-1:0] instr_addr,
   input wire                   instr_ready,
   input wire                   operand_bit,
   // Results
   input wire                   bit_wr_en_r,
   input wire [`LBE_ADDR_W-1:0] bit_wr_addr_r,
   input wire                   bit_wr_data_r,
   input wire                   result_r,
   input wire [`LBE_STEP_W-1:0] instr_steps_r,
   input wire                   done_r,
   input wire                   prog_error_r,
   input wire [1:0]             error_code_r,
   input wire [`LBE_SP_W-1:0]   stack_level_r
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   wire take = instr_valid & instr_ready;
   a_load_value: assert property (take && instr_op == `LBE_OP_LOAD
      |-> ##2 done_r && result_r == $past(operand_bit, 2))
      else $error("load result differs from operand");
   a_load_inv: assert property (take && instr_op == `LBE_OP_LOAD_INV
      |-> ##2 done_r && result_r == !$past(operand_bit, 2))
      else $error("inverted load result wrong");
   a_coil_copy: assert property (take && instr_op == `LBE_OP_COIL
      |-> ##2 bit_wr_en_r && bit_wr_data_r == $past(result_r, 2)
      && bit_wr_addr_r == $past(instr_addr, 2))
      else $error("coil write does not carry result");
   a_invert_one: assert property (take && instr_op == `LBE_OP_INVERT
      |-> ##2 result_r == !$past(result_r, 2) && instr_steps_r == 2'h1)
      else $error("invert wrong");
   a_series_and: assert property (take && instr_op == `LBE_OP_SER
      |-> ##2 result_r == ($past(result_r, 2) & $past(operand_bit, 2)))
      else $error("series contact wrong");
   a_par_or: assert property (take && instr_op == `LBE_OP_PAR
      |-> ##2 result_r == ($past(result_r, 2) | $past(operand_bit, 2)))
      else $error("parallel contact wrong");
   a_toggle_steps: assert property (take
      && instr_op == `LBE_OP_TOGGLE |-> ##2 done_r && instr_steps_r == 2'h3)
      else $error("toggle step count wrong");
   a_push_keeps: assert property (take && instr_op == `LBE_OP_PUSH
      && stack_level_r < 4'h8 |-> ##2 result_r == $past(result_r, 2)
      && stack_level_r == $past(stack_level_r, 2) + 4'h1)
      else $error("push changed result or level");
   a_pop_level: assert property (take && instr_op == `LBE_OP_POP
      && stack_level_r != 4'h0
      |-> ##2 stack_level_r == $past(stack_level_r, 2) - 4'h1)
      else $error("pop level wrong");
   a_under_flag: assert property (take && instr_op == `LBE_OP_POP
      && stack_level_r == 4'h0 |-> ##2 prog_error_r && error_code_r == 2'h2)
      else $error("underflow not flagged");
endmodule
bind lbe_engine lbe_engine_chk u_chk (
   .clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
   .instr_op(instr_op), .instr_addr(instr_addr), .instr_ready(instr_ready),
   .operand_bit(operand_bit), .bit_wr_en_r(bit_wr_en_r),
   .bit_wr_addr_r(bit_wr_addr_r), .bit_wr_data_r(bit_wr_data_r),
   .result_r(result_r), .instr_steps_r(instr_steps_r), .done_r(done_r),
   .prog_error_r(prog_error_r), .error_code_r(error_code_r),
   .stack_level_r(stack_level_r));

// *** verification/tb_top.sv ***
// Self-checking bench for the boolean engine.
`timescale 1ns/10ps
`include "lbe_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic clock, reset_n, instr_valid, instr_ext, scan_start, instr_ready;
   logic operand_bit, bit_wr_en_r, bit_wr_data_r, result_r, done_r;
   logic prog_error_r;
   logic [4:0]  instr_op;
   logic [15:0] instr_addr, bit_wr_addr_r;
   logic [7:0]  instr_edge_id;
   logic [1:0]  instr_steps_r, error_code_r;
   logic [3:0]  stack_level_r;
   int          n_errors, compares;
   lbe_engine u_dut (.clock(clock), .reset_n(reset_n),
      .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_addr(instr_addr), .instr_ext(instr_ext),
      .instr_edge_id(instr_edge_id), .scan_start(scan_start),
      .instr_ready(instr_ready), .operand_bit(operand_bit),
      .bit_wr_en_r(bit_wr_en_r), .bit_wr_addr_r(bit_wr_addr_r),
      .bit_wr_data_r(bit_wr_data_r), .result_r(result_r),
      .instr_steps_r(instr_steps_r), .done_r(done_r),
      .prog_error_r(prog_error_r), .error_code_r(error_code_r),
      .stack_level_r(stack_level_r));
   lbe_bit_mem u_mem (.clock(clock), .rd_addr(instr_addr),
      .rd_bit(operand_bit), .wr_en(bit_wr_en_r),
      .wr_addr(bit_wr_addr_r), .wr_data(bit_wr_data_r));
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   task summarize;
      begin
         if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // The leading idle edge lets the previous coil write land first.
   task ex(input [4:0] op, input [15:0] a, input e, input [7:0] id,
           input r, input [1:0] st);
      int k;
      begin
         @(posedge clock);
         #1 instr_op = op;
         instr_addr = a;
         instr_ext = e;
         instr_edge_id = id;
         instr_valid = 1'h1;
         k = 0;
         while (instr_ready !== 1'h1 && k < 20) begin
            @(posedge clock);
            #1 k++;
         end
         @(posedge clock);
         #1 instr_valid = 1'h0;
         @(posedge clock);
         #1 `CHK(done_r, 1'h1)
         `CHK(result_r, r)
         `CHK(instr_steps_r, st)
      end
   endtask
   task t_basic;
      begin
         ex(`LBE_OP_LOAD, 16'h1, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_LOAD_INV, 16'h1, 1'h1, 8'h0, 1'h0, 2'h2);
         ex(`LBE_OP_PAR, 16'h1, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_SER_INV, 16'h1, 1'h1, 8'h0, 1'h0, 2'h2);
         ex(`LBE_OP_PAR_INV, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_SER, 16'h0, 1'h1, 8'h0, 1'h0, 2'h2);
         ex(`LBE_OP_INVERT, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_COIL, 16'h2, 1'h1, 8'h0, 1'h1, 2'h2);
         `CHK({bit_wr_en_r, bit_wr_data_r, bit_wr_addr_r}, 18'h30002)
         ex(`LBE_OP_LOAD, 16'h2, 1'h0, 8'h0, 1'h1, 2'h1);
      end
   endtask
   task t_stack;
      int k;
      begin
         ex(`LBE_OP_LOAD, 16'h1, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_PUSH, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_LOAD, 16'h0, 1'h0, 8'h0, 1'h0, 2'h1);
         ex(`LBE_OP_PEEK, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         `CHK(stack_level_r, 4'h1)
         ex(`LBE_OP_LOAD, 16'h0, 1'h0, 8'h0, 1'h0, 2'h1);
         ex(`LBE_OP_POP, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         `CHK(stack_level_r, 4'h0)
         ex(`LBE_OP_PUSH, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_LOAD, 16'h0, 1'h0, 8'h0, 1'h0, 2'h1);
         ex(`LBE_OP_BLK_SER, 16'h0, 1'h0, 8'h0, 1'h0, 2'h1);
         ex(`LBE_OP_PUSH, 16'h0, 1'h0, 8'h0, 1'h0, 2'h1);
         ex(`LBE_OP_LOAD, 16'h1, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_BLK_PAR, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         ex(`LBE_OP_POP, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         `CHK({prog_error_r, error_code_r}, 3'h6)
         scan_start = 1'h1;
         @(posedge clock);
         #1 scan_start = 1'h0;
         `CHK(prog_error_r, 1'h0)
         for (k = 0; k < 9; k++)
            ex(`LBE_OP_PUSH, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
         `CHK({stack_level_r, error_code_r}, 6'h21)
         for (k = 0; k < 8; k++)
            ex(`LBE_OP_POP, 16'h0, 1'h0, 8'h0, 1'h1, 2'h1);
      end
   endtask
   // Each edge form uses its own slot on one shared operand bit.
   task t_edge;
      logic [4:0] op;
      logic       v, b, t, p, x;
      int         i, j;
      begin
         for (i = 0; i < 6; i++) begin
            op = `LBE_OP_LOAD_RISE + i[4:0];
            p = 1'h0;
            for (j = 0; j < 5; j++) begin
               v = (j != 2 && j != 3);
               b = j[0];
               ex(`LBE_OP_LOAD, {15'h0, v}, 1'h0, 8'h0, v, 2'h1);
               ex(`LBE_OP_COIL, 16'h4, 1'h0, 8'h0, v, 2'h1);
               ex(`LBE_OP_LOAD, {15'h0, b}, 1'h0, 8'h0, b, 2'h1);
               t = i[0] ? (p & !v) : (v & !p);
               x = i < 2 ? t : i < 4 ? b & t : b | t;
               ex(op, 16'h4, 1'h0, 8'h10 + i[7:0], x, 2'h2);
               p = v;
            end
         end
      end
   endtask
   task t_pulse;
      logic [4:0] op;
      logic       v, p, e, m;
      int         i, j;
      begin
         m = 1'h1;
         for (i = 0; i < 5; i++) begin
            op = i < 3 ? `LBE_OP_PULS_RISE + i[4:0]
                       : `LBE_OP_RISE_PLS + i[4:0] - 5'h3;
            p = 1'h0;
            for (j = 0; j < 5; j++) begin
               v = (j != 2 && j != 3);
               e = (i == 1 || i == 4) ? (p & !v) : (v & !p);
               ex(`LBE_OP_LOAD, {15'h0, v}, 1'h0, 8'h0, v, 2'h1);
               if (i < 2) begin
                  ex(op, 16'h6, 1'h0, 8'h20 + i[7:0], v, 2'h2);
                  `CHK({bit_wr_en_r, bit_wr_data_r}, {1'h1, e})
               end else if (i == 2) begin
                  ex(op, 16'h5, 1'h0, 8'h22, v, 2'h3);
                  `CHK(bit_wr_en_r, e)
                  m = e ? !m : m;
                  if (e)
                     `CHK(bit_wr_data_r, m)
               end else
                  ex(op, 16'h0, 1'h0, 8'h20 + i[7:0], e, 2'h1);
               p = v;
            end
         end
      end
   endtask
   initial begin
      n_errors = 0;
      compares = 0;
      reset_n = 1'h0;
      {instr_valid, instr_ext, scan_start} = 3'h0;
      {instr_op, instr_addr, instr_edge_id} = 29'h0;
      repeat (16) @(posedge clock);
      #1 reset_n = 1'h1;
      `CHK({instr_ready, prog_error_r, stack_level_r}, 6'h20)
      t_basic;
      t_stack;
      t_edge;
      t_pulse;
      summarize;
   end
   initial begin
      #400000;
      n_errors++;
      summarize;
   end
endmodule
